// ### src/ssc_pkg.sv
`default_nettype none
// ****************************************************************
// constants for the serial sram command port
// ****************************************************************
package ssc_pkg;

  // instruction codes
  localparam logic [7:0] read_array_cmd = 8'h03;
  localparam logic [7:0] write_array_cmd = 8'h02;
  localparam logic [7:0] enter_dual_io_cmd = 8'h3B;
  localparam logic [7:0] exit_dual_io_cmd = 8'hFF;
  localparam logic [7:0] read_mode_reg_cmd = 8'h05;
  localparam logic [7:0] write_mode_reg_cmd = 8'h01;

  // operating mode register layout and values
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;
  localparam logic [7:0] MODE_RESET = 8'h40;

  // frame geometry
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 17;
  localparam int PAGE_BITS = 5;
  localparam logic [4:0] BYTE_LEN = 5'h08;
  localparam logic [4:0] ADDR_FRAME_LEN = 5'h18;
  localparam logic [4:0] STEP_SINGLE = 5'h01;
  localparam logic [4:0] STEP_DUAL = 5'h02;

  // command sequencer states, gray along cmd, addr, dummy, data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h6,
    ST_IGNORE = 3'h7
  } ssc_state_t;

  // decoded operation kept for the data phase
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_MODE_RD = 2'h2,
    OP_MODE_WR = 2'h3
  } ssc_op_t;

endpackage
`default_nettype wire

// ### src/ssc_sram_port.sv
`timescale 1ns/1ps
`default_nettype none
module ssc_sram_port #(
  parameter int ADDR_W = ssc_pkg::ADDR_BITS
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in_dual_bit0_i,
  output logic serial_in_dual_bit0_o,
  output logic serial_in_dual_bit0_oe_n,
  input wire logic serial_out_dual_bit1_i,
  output logic serial_out_dual_bit1_o,
  output logic serial_out_dual_bit1_oe_n,
  output logic two_bit_interface_mode,
  output logic [ssc_pkg::BYTE_BITS-1:0] operating_mode_reg
);
  import ssc_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] ONE_ADDR = {{(ADDR_W-1){1'b0}}, 1'b1};

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [2:0] cs_sync_ff; // select, third stage for edge detect
  logic [2:0] clk_sync_ff; // serial clock, third stage for edges
  logic [1:0] d0_sync_ff; // data pin 0
  logic [1:0] d1_sync_ff; // data pin 1

  // two flops per pin; the data pins share the clock's latency so
  // a sampled bit lines up with the detected edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cs_sync_ff <= 3'h7;
      clk_sync_ff <= 3'h0;
      d0_sync_ff <= 2'h0;
      d1_sync_ff <= 2'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], chip_select_n};
      clk_sync_ff <= {clk_sync_ff[1:0], serial_clk};
      d0_sync_ff <= {d0_sync_ff[0], serial_in_dual_bit0_i};
      d1_sync_ff <= {d1_sync_ff[0], serial_out_dual_bit1_i};
    end
  end

  wire cs_high = cs_sync_ff[1];
  wire cs_fall = cs_sync_ff[2] & ~cs_sync_ff[1];
  wire sclk_rise = clk_sync_ff[1] & ~clk_sync_ff[2];
  wire sclk_fall = ~clk_sync_ff[1] & clk_sync_ff[2];
  wire bit0 = d0_sync_ff[1];
  wire bit1 = d1_sync_ff[1];

  // ****************************************************************
  // state and storage
  // ****************************************************************
  ssc_state_t state_ff, nxt_state; // command sequencer
  ssc_op_t op_ff, nxt_op; // operation of the current frame
  logic dual_ff, nxt_dual; // two-bit interface active
  logic [7:0] mode_ff; // operating mode register
  logic [ADDR_W-1:0] addr_ff; // byte address pointer
  logic [7:0] rx_ff; // incoming shift register
  logic [7:0] tx_ff; // outgoing shift register
  logic [4:0] cnt_ff; // bits taken in the current field
  logic out_ff, nxt_out; // device is in an output phase
  logic pin1_ff, pin0_ff; // pin data
  logic pin1_oe_n_ff, pin0_oe_n_ff; // pin enables, low drives
  logic [7:0] mem [0:DEPTH-1]; // the storage array

  // ****************************************************************
  // datapath decode
  // ****************************************************************
  // next pointer; byte mode steps like sequential, but the frame ends after that byte
  function automatic logic [ADDR_W-1:0] next_addr(
    input logic [ADDR_W-1:0] a,
    input logic [1:0] m
  );
    logic [ADDR_W-1:0] inc;
    inc = a + ONE_ADDR;
    if (m == MODE_PAGE) begin
      // keep the page, wrap the offset; 33rd byte overwrites 1st
      next_addr = {a[ADDR_W-1:PAGE_BITS], inc[PAGE_BITS-1:0]};
    end else begin
      next_addr = inc; // rolls over to zero at the top
    end
  endfunction

  wire [1:0] mode_field = mode_ff[MODE_HI:MODE_LO];
  wire [4:0] step = dual_ff ? STEP_DUAL : STEP_SINGLE;
  wire [4:0] cnt_sum = cnt_ff + step;
  wire [4:0] target = (state_ff == ST_ADDR) ? ADDR_FRAME_LEN : BYTE_LEN;
  wire done = sclk_rise & ~cs_high & (cnt_sum == target);
  // msb arrives first, so shift towards the top
  wire [7:0] rx_shift = dual_ff ? {rx_ff[5:0], bit1, bit0}
                                : {rx_ff[6:0], bit0};
  // only the low address bits are kept; the rest fall off
  wire [ADDR_W-1:0] addr_shift = dual_ff
    ? {addr_ff[ADDR_W-3:0], bit1, bit0}
    : {addr_ff[ADDR_W-2:0], bit0};
  wire [ADDR_W-1:0] addr_next = next_addr(addr_ff, mode_field);
  wire [ADDR_W-PAGE_BITS-1:0] page_id = addr_ff[ADDR_W-1:PAGE_BITS];
  wire cmd_done = (state_ff == ST_CMD) & done;
  wire data_done = (state_ff == ST_DATA) & done;
  wire is_rw = (op_ff == OP_READ) | (op_ff == OP_WRITE);
  wire adv = data_done & is_rw;
  wire mem_we = data_done & (op_ff == OP_WRITE);
  // a reserved mode code is not taken, so the field stays legal
  wire mode_we = data_done & (op_ff == OP_MODE_WR)
               & (rx_shift[MODE_HI:MODE_LO] != MODE_RSVD);
  wire first_rd = (state_ff == ST_ADDR) & done & (op_ff == OP_READ);
  wire dummy_done = (state_ff == ST_DUMMY) & done;
  wire mode_rd_load = (cmd_done & (rx_shift == read_mode_reg_cmd))
                    | (data_done & (op_ff == OP_MODE_RD));
  wire tx_load = first_rd | dummy_done | mode_rd_load
               | (adv & (op_ff == OP_READ));
  // two-bit reads open with a dummy byte of zeros
  wire [7:0] tx_src = mode_rd_load ? mode_ff
                    : first_rd ? (dual_ff ? 8'h00 : mem[addr_shift])
                    : dummy_done ? mem[addr_ff]
                    : mem[addr_next];
  wire [7:0] tx_shift = dual_ff ? {tx_ff[5:0], 2'h0} : {tx_ff[6:0], 1'h0};
  wire tx_msb = tx_ff[7];

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  // select high aborts everything; the host owns framing
  always_comb begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_dual = dual_ff;
    if (cs_high) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // a select already low at reset release still counts as a start; the synchroniser resets high
          if (cs_fall) begin
            nxt_state = ST_CMD;
          end
        end
        ST_CMD: begin
          if (done) begin
            nxt_state = ST_IGNORE;
            case (rx_shift)
              read_array_cmd: begin
                nxt_state = ST_ADDR;
                nxt_op = OP_READ;
              end
              write_array_cmd: begin
                nxt_state = ST_ADDR;
                nxt_op = OP_WRITE;
              end
              read_mode_reg_cmd: begin
                nxt_state = ST_DATA;
                nxt_op = OP_MODE_RD;
              end
              write_mode_reg_cmd: begin
                nxt_state = ST_DATA;
                nxt_op = OP_MODE_WR;
              end
              enter_dual_io_cmd: begin
                nxt_dual = 1'b1;
              end
              // decoded in both widths, harmless when single
              exit_dual_io_cmd: begin
                nxt_dual = 1'b0;
              end
              default: begin
                nxt_state = ST_IGNORE;
              end
            endcase
          end
        end
        ST_ADDR: begin
          if (done) begin
            nxt_state = (op_ff == OP_READ && dual_ff) ? ST_DUMMY
                                                        : ST_DATA;
          end
        end
        ST_DUMMY: begin
          if (done) begin
            nxt_state = ST_DATA;
          end
        end
        ST_DATA: begin
          // byte mode and mode writes stop after one byte
          if (adv && mode_field == MODE_BYTE) begin
            nxt_state = ST_IGNORE;
          end else if (data_done && op_ff == OP_MODE_WR) begin
            nxt_state = ST_IGNORE;
          end
        end
        default: begin
          nxt_state = ST_IGNORE; // waits for select to rise
        end
      endcase
    end
  end

  // output phase only in read-type data or dummy states
  assign nxt_out = ~cs_high
                 & ((nxt_state == ST_DATA) | (nxt_state == ST_DUMMY))
                 & ((nxt_op == OP_READ) | (nxt_op == OP_MODE_RD));

  // sequencer and mode flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      op_ff <= OP_READ;
      dual_ff <= 1'b0;
      mode_ff <= MODE_RESET; // sequential by default
      out_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      dual_ff <= nxt_dual;
      out_ff <= nxt_out;
      if (mode_we) begin
        mode_ff <= {rx_shift[MODE_HI:MODE_LO], 6'h00};
      end
    end
  end

  // ****************************************************************
  // shifters and pointer
  // ****************************************************************
  // bit counter restarts at each field and on every new frame
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= 5'h00;
    end else if (cs_high || state_ff == ST_IDLE || done) begin
      cnt_ff <= 5'h00;
    end else if (sclk_rise) begin
      cnt_ff <= cnt_sum;
    end
  end

  // receive shifter and address pointer, rising edge only
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_ff <= 8'h00;
      addr_ff <= '0;
    end else begin
      if (sclk_rise) begin
        rx_ff <= rx_shift;
      end
      if (state_ff == ST_ADDR && sclk_rise && !cs_high) begin
        addr_ff <= addr_shift;
      end else if (adv) begin
        addr_ff <= addr_next;
      end
    end
  end

  // array write; no reset, contents survive deselect
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[addr_ff] <= rx_shift;
    end
  end

  // transmit shifter loads on rising, shifts on falling edges
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_ff <= 8'h00;
      pin1_ff <= 1'b0;
      pin0_ff <= 1'b0;
    end else if (tx_load) begin
      tx_ff <= tx_src;
    end else if (sclk_fall && out_ff) begin
      // msb leaves first; in two-bit mode pin 1 carries the higher
      pin1_ff <= tx_ff[7];
      pin0_ff <= dual_ff ? tx_ff[6] : pin0_ff;
      tx_ff <= tx_shift;
    end
  end

  // enables switch with the phase in the same cycle; released when deselected
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin1_oe_n_ff <= 1'b1;
      pin0_oe_n_ff <= 1'b1;
    end else begin
      pin1_oe_n_ff <= ~nxt_out;
      pin0_oe_n_ff <= ~(nxt_out & dual_ff);
    end
  end

  assign serial_out_dual_bit1_o = pin1_ff;
  assign serial_out_dual_bit1_oe_n = pin1_oe_n_ff;
  assign serial_in_dual_bit0_o = pin0_ff;
  assign serial_in_dual_bit0_oe_n = pin0_oe_n_ff;
  assign two_bit_interface_mode = dual_ff;
  assign operating_mode_reg = mode_ff;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  property p_cs_idle;
    cs_high |=> (state_ff == ST_IDLE) && !out_ff;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("select high did not return sequencer to idle");

  property p_cs_release;
    cs_high |=> ##1 pin1_oe_n_ff && pin0_oe_n_ff;
  endproperty
  a_cs_release: assert property (p_cs_release)
    else $error("pins still driven while deselected");

  property p_standby;
    (state_ff == ST_IDLE) && !cs_fall |=> state_ff == ST_IDLE;
  endproperty
  a_standby: assert property (p_standby)
    else $error("left idle without a select falling edge");

  property p_read_cmd;
    cmd_done && (rx_shift == read_array_cmd)
      |=> (state_ff == ST_ADDR) && (op_ff == OP_READ);
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read instruction not decoded");

  property p_enter_dual;
    cmd_done && (rx_shift == enter_dual_io_cmd) |=> dual_ff;
  endproperty
  a_enter_dual: assert property (p_enter_dual)
    else $error("two-bit entry not taken");

  property p_exit_dual;
    cmd_done && (rx_shift == exit_dual_io_cmd) |=> !dual_ff;
  endproperty
  a_exit_dual: assert property (p_exit_dual)
    else $error("return to single-bit not taken");

  property p_dummy;
    first_rd && dual_ff |=> (state_ff == ST_DUMMY) && (tx_ff == 8'h00);
  endproperty
  a_dummy: assert property (p_dummy)
    else $error("two-bit read missing dummy byte");

  property p_page_wrap;
    adv && (mode_field == MODE_PAGE) |=> $stable(page_id);
  endproperty
  a_page_wrap: assert property (p_page_wrap)
    else $error("page mode crossed a page boundary");

  property p_seq_step;
    adv && (mode_field == MODE_SEQ)
      |=> addr_ff == ADDR_W'($past(addr_ff) + ONE_ADDR);
  endproperty
  a_seq_step: assert property (p_seq_step)
    else $error("sequential pointer did not step by one");

  property p_byte_stop;
    adv && (mode_field == MODE_BYTE)
      |=> (state_ff == ST_IGNORE) && !out_ff;
  endproperty
  a_byte_stop: assert property (p_byte_stop)
    else $error("byte mode moved more than one byte");

  property p_fall_only;
    !sclk_fall |=> $stable(pin1_ff);
  endproperty
  a_fall_only: assert property (p_fall_only)
    else $error("output changed without a falling edge");

  property p_msb_first;
    sclk_fall && out_ff && !dual_ff && !tx_load |=> pin1_ff == $past(tx_msb);
  endproperty
  a_msb_first: assert property (p_msb_first)
    else $error("output bit order wrong");

  property p_mode_read;
    cmd_done && (rx_shift == read_mode_reg_cmd) |=> tx_ff == mode_ff;
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode read did not load mode register");

  property p_mode_hold;
    !mode_we |=> $stable(mode_ff);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode register changed without a mode write");

  property p_mode_legal;
    mode_field != MODE_RSVD;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("mode field holds reserved code");

  c_read: cover property (first_rd ##[1:400] adv);
  c_write: cover property (mem_we);
  c_dual: cover property (cmd_done && rx_shift == enter_dual_io_cmd);
  c_page_wrap: cover property (adv && mode_field == MODE_PAGE
                               && addr_ff[PAGE_BITS-1:0] == 5'h1F);

endmodule
`default_nettype wire

// ### verification/ssc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// host controller model driving select, serial clock and data pins
// ****************************************************************
module ssc_host_model (
  input wire logic pin0,
  input wire logic pin1,
  output logic chip_select_n,
  output logic serial_clk,
  output logic drv0_en,
  output logic drv0_val,
  output logic drv1_en,
  output logic drv1_val
);
  // half period of the link clock, 48 ns period, free of ref_clk phase
  localparam realtime HALF = 24.0;

  // idle: deselected, clock parked low, data pins released
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    drv0_en = 1'b0;
    drv0_val = 1'b0;
    drv1_en = 1'b0;
    drv1_val = 1'b0;
  end

  // select falls with the clock low, so the frame starts cleanly
  task automatic open_frame();
    serial_clk <= 1'b0;
    #(HALF);
    chip_select_n <= 1'b0;
    #(HALF);
  endtask

  // release pins, then deselect; stay high well over three cycles
  task automatic close_frame();
    drv0_en <= 1'b0;
    drv1_en <= 1'b0;
    #(HALF);
    chip_select_n <= 1'b1;
    #(HALF * 2);
  endtask

  // one byte, msb first; two-bit puts the higher bit on pin1
  task automatic xfer(input logic [7:0] tx, input logic dual,
                      input logic drive, output logic [7:0] rx);
    int i;
    int lo;
    rx = 8'h00;
    for (i = 7; i >= 0; i -= (dual ? 2 : 1)) begin
      lo = dual ? i - 1 : i;
      // data changes only while the clock is low
      drv0_en <= drive;
      drv1_en <= drive & dual;
      drv0_val <= tx[lo];
      drv1_val <= tx[i];
      #(HALF);
      // read data was launched by the previous falling edge
      rx[i] = pin1;
      if (dual) begin
        rx[lo] = pin0;
      end
      serial_clk <= 1'b1;
      #(HALF);
      serial_clk <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// self-checking bench for the serial sram command port
// ****************************************************************
module testbench;
  import ssc_pkg::*;
  logic ref_clk;
  logic resetn;
  logic tog_ff; // stands in for a floating line
  wire logic cs_n, sclk, pin0_w, pin1_w;
  wire logic h0_en, h0_v, h1_en, h1_v;
  wire logic s0_o, s0_oe_n, s1_o, s1_oe_n, dual_mode;
  wire logic [7:0] mode_q;
  int miscompares;
  int samples_checked;
  logic [7:0] q [$]; // data of the last transfer
  logic [7:0] v;
  int i;

  // pin levels: device first, then host, else a changing pattern
  assign pin0_w = !s0_oe_n ? s0_o : (h0_en ? h0_v : tog_ff);
  assign pin1_w = !s1_oe_n ? s1_o : (h1_en ? h1_v : tog_ff);

  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tog_ff <= ~tog_ff;

  ssc_sram_port #(.ADDR_W(ADDR_BITS)) dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .chip_select_n(cs_n),
    .serial_clk(sclk), .serial_in_dual_bit0_i(pin0_w),
    .serial_in_dual_bit0_o(s0_o), .serial_in_dual_bit0_oe_n(s0_oe_n),
    .serial_out_dual_bit1_i(pin1_w), .serial_out_dual_bit1_o(s1_o),
    .serial_out_dual_bit1_oe_n(s1_oe_n),
    .two_bit_interface_mode(dual_mode), .operating_mode_reg(mode_q)
  );

  ssc_host_model host_u (
    .pin0(pin0_w), .pin1(pin1_w), .chip_select_n(cs_n),
    .serial_clk(sclk), .drv0_en(h0_en), .drv0_val(h0_v),
    .drv1_en(h1_en), .drv1_val(h1_v)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // instruction and 24-bit address, frame left open
  task automatic hdr(input logic [7:0] c, input logic [23:0] a,
                     input logic dual);
    logic [7:0] rx;
    host_u.open_frame();
    host_u.xfer(c, dual, 1'b1, rx);
    for (int k = 2; k >= 0; k--) begin
      host_u.xfer(a[k*8 +: 8], dual, 1'b1, rx);
    end
  endtask

  task automatic wr(input logic [23:0] a, input logic dual);
    logic [7:0] rx;
    hdr(write_array_cmd, a, dual);
    foreach (q[k]) host_u.xfer(q[k], dual, 1'b1, rx);
    host_u.close_frame();
  endtask

  // two-bit read checks the dummy byte is zero before collecting data
  task automatic rd(input logic [23:0] a, input int n, input logic dual);
    logic [7:0] rx;
    hdr(read_array_cmd, a, dual);
    if (dual) begin
      host_u.xfer(8'h00, 1'b1, 1'b0, rx);
      chk("dummy byte", 8'h00, rx);
    end
    q.delete();
    repeat (n) begin
      host_u.xfer(8'h00, dual, !dual, rx);
      q.push_back(rx);
    end
    host_u.close_frame();
    chk("pin1 enable after deselect", 8'h01, {7'h0, s1_oe_n});
  endtask

  // one-byte instruction, optionally followed by one byte each way
  task automatic cmd(input logic [7:0] c, input logic dual, input int n,
                     input logic [7:0] tx, output logic [7:0] rx);
    host_u.open_frame();
    host_u.xfer(c, dual, 1'b1, rx);
    if (n > 0) begin
      host_u.xfer(tx, dual, c != read_mode_reg_cmd, rx);
    end
    host_u.close_frame();
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    tog_ff = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("mode after reset", MODE_RESET, mode_q);
    chk("enables after reset", 8'h03, {6'h0, s1_oe_n, s0_oe_n});
    repeat (4) @(posedge ref_clk);
    cmd(read_mode_reg_cmd, 1'b0, 1, 8'h00, v);
    chk("mode read", MODE_RESET, v);
    // sequential write over the array top, junk in ignored bits
    q = '{8'hA0, 8'hA1, 8'hA2};
    wr(24'hFF_FFFE, 1'b0);
    rd(24'h01_FFFE, 3, 1'b0);
    for (i = 0; i < 3; i++) chk("seq read", 8'(8'hA0 + i), q[i]);
    // reserved code refused, reserved bits kept at zero
    cmd(write_mode_reg_cmd, 1'b0, 1, 8'hC0, v);
    chk("reserved mode", MODE_RESET, mode_q);
    cmd(write_mode_reg_cmd, 1'b0, 1, 8'hBF, v);
    chk("page mode", 8'h80, mode_q);
    // 33 bytes into one page: the last lands on the first
    q.delete();
    for (i = 0; i < 33; i++) q.push_back(8'(8'h10 + i));
    wr(24'h00_041E, 1'b0);
    rd(24'h00_041E, 33, 1'b0);
    for (i = 0; i < 33; i++) begin
      chk("page read", (i % 32 == 0) ? 8'h30 : 8'(8'h10 + i), q[i]);
    end
    // byte mode takes only the first data byte
    cmd(write_mode_reg_cmd, 1'b0, 1, 8'h00, v);
    q = '{8'h55, 8'h66};
    wr(24'h00_041E, 1'b0);
    rd(24'h00_041E, 1, 1'b0);
    chk("byte read", 8'h55, q[0]);
    cmd(write_mode_reg_cmd, 1'b0, 1, 8'h40, v);
    rd(24'h00_041E, 2, 1'b0);
    chk("byte write next", 8'h11, q[1]);
    // truncated header dropped at deselect
    host_u.open_frame();
    host_u.xfer(write_array_cmd, 1'b0, 1'b1, v);
    host_u.xfer(8'h00, 1'b0, 1'b1, v);
    host_u.close_frame();
    // an unknown instruction must not act as a mode write
    cmd(8'hA5, 1'b0, 1, 8'h80, v);
    chk("mode after unknown", MODE_RESET, mode_q);
    cmd(read_mode_reg_cmd, 1'b0, 1, 8'h00, v);
    chk("mode after partial", MODE_RESET, v);
    // two-bit interface round trip
    cmd(enter_dual_io_cmd, 1'b0, 0, 8'h00, v);
    chk("two-bit on", 8'h01, {7'h0, dual_mode});
    q = '{8'hC3, 8'h5A};
    wr(24'h00_0200, 1'b1);
    rd(24'h00_0200, 2, 1'b1);
    chk("dual read 0", 8'hC3, q[0]);
    chk("dual read 1", 8'h5A, q[1]);
    // entering two-bit again while already there keeps it
    cmd(enter_dual_io_cmd, 1'b1, 0, 8'h00, v);
    chk("two-bit stays", 8'h01, {7'h0, dual_mode});
    cmd(read_mode_reg_cmd, 1'b1, 1, 8'h00, v);
    chk("dual mode read", MODE_RESET, v);
    cmd(exit_dual_io_cmd, 1'b1, 0, 8'h00, v);
    chk("two-bit off", 8'h00, {7'h0, dual_mode});
    cmd(exit_dual_io_cmd, 1'b0, 0, 8'h00, v);
    chk("single stays", 8'h00, {7'h0, dual_mode});
    results();
  end

  // watchdog well past the expected run of about 53 us
  initial begin
    #300000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
